// ==== hw/axis_flags_pkg.sv ====
package axis_flags_pkg;

    // Register indices
    localparam logic [3:0] REG_STATUS    = 4'h0;  // Flags, read only
    localparam logic [3:0] REG_FAULT     = 4'h1;  // Fault flags
    localparam logic [3:0] REG_HW_CAUSE  = 4'h2;  // Hardware causes
    localparam logic [3:0] REG_ERR_INFO  = 4'h3;  // Failed write info
    localparam logic [3:0] REG_COMMAND   = 4'h4;  // Command pulses
    localparam logic [3:0] REG_CLASS     = 4'h5;  // Fault classes
    localparam logic [3:0] REG_IRQ_STAT  = 4'h6;  // Sticky events
    localparam logic [3:0] REG_IRQ_MASK  = 4'h7;  // Interrupt enables

    // Status fields
    localparam int ST_DRIVE_ON   = 0;
    localparam int ST_HALTED     = 1;
    localparam int ST_PENDING    = 2;
    localparam int ST_W_ARMED    = 3;
    localparam int ST_W_HIT      = 4;
    localparam int ST_L_ARMED    = 5;  // Two bits
    localparam int ST_L_HIT      = 7;  // Two bits

    // Fault and class fields
    localparam int FT_HW         = 0;
    localparam int FT_UNIT       = 1;
    localparam int FT_WRITE      = 2;
    localparam int FT_LINK       = 3;

    // Command fields
    localparam int CM_ARM_WATCH  = 0;
    localparam int CM_DIS_WATCH  = 1;
    localparam int CM_ARM_LATCH  = 2;  // Two bits
    localparam int CM_DIS_LATCH  = 4;  // Two bits
    localparam int CM_SET_WRITE  = 6;

    // Event fields
    localparam int EV_W_HIT      = 0;
    localparam int EV_L_HIT      = 1;  // Two bits
    localparam int EV_HW         = 3;
    localparam int EV_UNIT       = 4;
    localparam int EV_WRITE      = 5;
    localparam int EV_LINK       = 6;
    localparam int EV_UPD_DONE   = 7;
    localparam int EV_W          = 8;

    // Reset values
    localparam logic [7:0]  CLASS_RST = 8'h00;  // All non-major
    localparam logic [7:0]  MASK_RST  = 8'h00;  // All masked

    // Misses ridden through
    localparam int MISS_LIMIT = 4;

    // Latch inputs
    localparam int LATCH_N = 2;

    // Watchdog states
    typedef enum logic [0:0] {
        LNK_UP   = 1'b0,
        LNK_LOST = 1'b1
    } link_state_e;

endpackage

// ==== hw/axis_status_fault_flags.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RL1) Drive flag follows drive enable
// (RL2) Halted flag high in shutdown
// (RL3) Pending sets on update launch
// (RL4) Pending clears on good reply
// (RL5) Dependants wait for pending clear; the code only shows pending in status and holds back no new launch
// (RL6) Hardware fault sets on any cause
// (RL7) Three faults classed major or minor
// (RL8) Unit fatal sets on module fault
// (RL9) Only reconfiguration clears unit fatal
// (RL10) Failed write: flag, code, identifier
// (RL11) Five misses: link fault, shutdown
// (RL12) Link fault clears on reconnection
// (RL13) Watch armed: set by arm, cleared event/disarm
// (RL14) Watch hit: set by event, cleared arm/disarm
// (RL15) Latch-1 armed: set arm, clear event/disarm
// (RL16) Latch-1 hit: set event, clear arm/disarm
// (RL17) Latch-2 armed: set arm, clear event/disarm
// (RL18) Latch-2 hit: set event, clear arm/disarm
// (RL19) Flags clocked; newer event wins coincidences
module axis_status_fault_flags
    import axis_flags_pkg::*;
#(
    parameter int CAUSE_W = 8,  // Number of hardware fault causes
    parameter int CODE_W  = 8   // Width of error code and identifier
) (
    input  wire logic               i_mclk,
    input  wire logic               i_sys_rst,
    // Register port
    input  wire logic [3:0]         i_addr,
    input  wire logic [31:0]        i_wr_data,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [31:0]        o_rd_data,
    // Axis state
    input  wire logic               i_drive_en,
    input  wire logic               i_shutdown_state,
    input  wire logic [CAUSE_W-1:0] i_hw_fault_causes,
    input  wire logic               i_unit_fault,
    input  wire logic               i_unit_reconfig_done,
    // Setting updates
    input  wire logic               i_fw_setting_update,
    input  wire logic               i_update_ok,
    input  wire logic               i_update_fail,
    input  wire logic [CODE_W-1:0]  i_err_code,
    input  wire logic [CODE_W-1:0]  i_err_id,
    // Cyclic link
    input  wire logic               i_update_slot,
    input  wire logic               i_pos_update,
    input  wire logic               i_link_reestablished,
    // Events
    input  wire logic               i_watch_event,
    input  wire logic [LATCH_N-1:0] i_latch_event,
    // Flag outputs
    output logic                    o_drive_output_on_flag,
    output logic                    o_axis_halted_flag,
    output logic                    o_setting_update_pending,
    output logic                    o_axis_hw_fault,
    output logic                    o_unit_fatal_fault,
    output logic                    o_setting_write_failed,
    output logic                    o_cyclic_link_lost,
    output logic                    o_watch_armed,
    output logic                    o_watch_hit,
    output logic [LATCH_N-1:0]      o_latch_armed,
    output logic [LATCH_N-1:0]      o_latch_hit,
    output logic                    o_major_fault,
    output logic                    o_minor_fault,
    output logic                    o_servo_shutdown,
    output logic                    o_irq
);

    // Register decode
    logic                wr_fault;       // Fault write
    logic                wr_cause;       // Cause write
    logic                wr_cmd;         // Command write
    logic                wr_class;       // Class write
    logic                wr_istat;       // Status write
    logic                wr_imask;       // Mask write

    // Command pulses
    logic                arm_watch_cmd;
    logic                disarm_watch_cmd;
    logic [LATCH_N-1:0]  arm_latch_cmd;
    logic [LATCH_N-1:0]  disarm_latch_cmd;
    logic                program_setting_write_cmd;

    // Stored state
    logic [CAUSE_W-1:0]  cause_q;        // Sticky hardware causes
    logic [CODE_W-1:0]   err_code_q;     // Last failure code
    logic [CODE_W-1:0]   err_id_q;       // Last failure id
    logic [7:0]          class_q;        // One means major
    logic [EV_W-1:0]     istat_q;        // Sticky interrupt events
    logic [EV_W-1:0]     imask_q;        // Interrupt enables
    logic [EV_W-1:0]     ev_set;         // New events
    logic                link_lost_pulse;
    logic [3:0]          faults;         // Fault flags
    logic                major_d;
    logic                minor_d;

    assign wr_fault  = i_wr && (i_addr == REG_FAULT);
    assign wr_cause  = i_wr && (i_addr == REG_HW_CAUSE);
    assign wr_cmd    = i_wr && (i_addr == REG_COMMAND);
    assign wr_class  = i_wr && (i_addr == REG_CLASS);
    assign wr_istat  = i_wr && (i_addr == REG_IRQ_STAT);
    assign wr_imask  = i_wr && (i_addr == REG_IRQ_MASK);

    assign arm_watch_cmd             = wr_cmd && i_wr_data[CM_ARM_WATCH];
    assign disarm_watch_cmd          = wr_cmd && i_wr_data[CM_DIS_WATCH];
    assign arm_latch_cmd             = {LATCH_N{wr_cmd}} & i_wr_data[CM_ARM_LATCH +: LATCH_N];
    assign disarm_latch_cmd          = {LATCH_N{wr_cmd}} & i_wr_data[CM_DIS_LATCH +: LATCH_N];
    assign program_setting_write_cmd = wr_cmd && i_wr_data[CM_SET_WRITE];

    // Drive and halted flags mirror the inputs
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_drive_output_on_flag <= 1'b0;
            o_axis_halted_flag     <= 1'b0;
        end else begin
            o_drive_output_on_flag <= i_drive_en;        // (RL1)
            o_axis_halted_flag     <= i_shutdown_state;  // (RL2)
        end
    end

    // Pending update; a new launch beats a reply
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_setting_update_pending <= 1'b0;
        end else if (i_fw_setting_update || program_setting_write_cmd) begin
            o_setting_update_pending <= 1'b1;  // (RL3)
        end else if (i_update_ok) begin
            o_setting_update_pending <= 1'b0;  // (RL4)
        end
    end

    // Causes stick until written one; a new cause wins
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cause_q <= '0;
        end else begin
            cause_q <= (cause_q & ~(wr_cause ? i_wr_data[CAUSE_W-1:0] : '0)) | i_hw_fault_causes;  // (RL6)
        end
    end

    // Hardware fault flag, cleared by write one
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_axis_hw_fault <= 1'b0;
        end else if (|i_hw_fault_causes) begin
            o_axis_hw_fault <= 1'b1;  // (RL6)
        end else if (wr_fault && i_wr_data[FT_HW]) begin
            o_axis_hw_fault <= 1'b0;
        end
    end

    // Unit fatal fault; only a reconfiguration clears it
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_unit_fatal_fault <= 1'b0;
        end else if (i_unit_fault) begin
            o_unit_fatal_fault <= 1'b1;  // (RL8)
        end else if (i_unit_reconfig_done) begin
            o_unit_fatal_fault <= 1'b0;  // (RL9)
        end
    end

    // Failed write; code and identifier kept for software
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_setting_write_failed <= 1'b0;
            err_code_q             <= '0;
            err_id_q               <= '0;
        end else if (i_update_fail) begin
            o_setting_write_failed <= 1'b1;        // (RL10)
            err_code_q             <= i_err_code;  // (RL10)
            err_id_q               <= i_err_id;    // (RL10)
        end else if (wr_fault && i_wr_data[FT_WRITE]) begin
            o_setting_write_failed <= 1'b0;
        end
    end

    // Counts missed updates in a row
    link_miss_watchdog #(
        .LIMIT        (MISS_LIMIT)
    ) u_watchdog (
        .i_mclk       (i_mclk),
        .i_sys_rst    (i_sys_rst),
        .i_slot       (i_update_slot),
        .i_update     (i_pos_update),
        .i_reconnect  (i_link_reestablished),
        .o_lost_pulse (link_lost_pulse)
    );

    // Link fault shuts the servo down until reconnection
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_cyclic_link_lost <= 1'b0;
            o_servo_shutdown   <= 1'b0;
        end else if (link_lost_pulse) begin
            o_cyclic_link_lost <= 1'b1;  // (RL11)
            o_servo_shutdown   <= 1'b1;  // (RL11)
        end else if (i_link_reestablished) begin
            o_cyclic_link_lost <= 1'b0;  // (RL12)
            o_servo_shutdown   <= 1'b0;
        end
    end

    // Watch flags; arm beats event, event beats hit clear
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_watch_armed <= 1'b0;
            o_watch_hit   <= 1'b0;
        end else begin
            if (arm_watch_cmd) begin
                o_watch_armed <= 1'b1;  // (RL13)
            end else if (disarm_watch_cmd || (i_watch_event && o_watch_armed)) begin
                o_watch_armed <= 1'b0;  // (RL13)
            end
            if (i_watch_event && o_watch_armed) begin
                o_watch_hit <= 1'b1;    // (RL14)
            end else if (arm_watch_cmd || disarm_watch_cmd) begin
                o_watch_hit <= 1'b0;    // (RL14)
            end
        end
    end

    // Armed and hit pair per input
    // Disarmed inputs ignore events so stray edges report no hit
    for (genvar g = 0; g < LATCH_N; g++) begin : g_latch
        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
                o_latch_armed[g] <= 1'b0;
                o_latch_hit[g]   <= 1'b0;
            end else begin
                if (arm_latch_cmd[g]) begin
                    o_latch_armed[g] <= 1'b1;  // (RL15) (RL17)
                end else if (disarm_latch_cmd[g] || (i_latch_event[g] && o_latch_armed[g])) begin
                    o_latch_armed[g] <= 1'b0;  // (RL15) (RL17)
                end
                if (i_latch_event[g] && o_latch_armed[g]) begin
                    o_latch_hit[g] <= 1'b1;    // (RL16) (RL18)
                end else if (arm_latch_cmd[g] || disarm_latch_cmd[g]) begin
                    o_latch_hit[g] <= 1'b0;    // (RL16) (RL18)
                end
            end
        end
    end

    // Fault classes, software writable
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            class_q <= CLASS_RST;
        end else if (wr_class) begin
            class_q <= i_wr_data[7:0];  // (RL7)
        end
    end

    // Split faults into major and non-major; link loss is major
    assign faults = {o_cyclic_link_lost, o_setting_write_failed, o_unit_fatal_fault, o_axis_hw_fault};

    always_comb begin
        major_d = faults[FT_LINK];
        minor_d = 1'b0;
        for (int k = FT_HW; k <= FT_WRITE; k++) begin
            if (faults[k] && class_q[k]) begin
                major_d = 1'b1;  // (RL7)
            end else if (faults[k]) begin
                minor_d = 1'b1;  // (RL7)
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_major_fault <= 1'b0;
            o_minor_fault <= 1'b0;
        end else begin
            o_major_fault <= major_d;
            o_minor_fault <= minor_d;
        end
    end

    // Interrupt events: hits, faults and update completion
    always_comb begin
        ev_set                     = '0;
        ev_set[EV_W_HIT]           = i_watch_event && o_watch_armed;
        ev_set[EV_L_HIT +: LATCH_N] = i_latch_event & o_latch_armed;
        ev_set[EV_HW]              = |i_hw_fault_causes;
        ev_set[EV_UNIT]            = i_unit_fault;
        ev_set[EV_WRITE]           = i_update_fail;
        ev_set[EV_LINK]            = link_lost_pulse;
        ev_set[EV_UPD_DONE]        = i_update_ok && o_setting_update_pending;
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            istat_q <= '0;
        end else begin
            istat_q <= (istat_q & ~(wr_istat ? i_wr_data[EV_W-1:0] : '0)) | ev_set;  // (RL19)
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            imask_q <= MASK_RST;
        end else if (wr_imask) begin
            imask_q <= i_wr_data[EV_W-1:0];
        end
    end

    // Level interrupt, a cycle late so the output is a flop
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(istat_q & imask_q);
        end
    end

    // Read data stand one cycle after the strobe, else zero
    // Unmapped and write-only read zero
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rd_data <= 32'h0;
        end else begin
            o_rd_data <= 32'h0;
            if (i_rd) begin
                case (i_addr)
                    REG_STATUS: begin
                        o_rd_data[ST_DRIVE_ON] <= o_drive_output_on_flag;
                        o_rd_data[ST_HALTED] <= o_axis_halted_flag;
                        o_rd_data[ST_PENDING] <= o_setting_update_pending;  // (RL5)
                        o_rd_data[ST_W_ARMED] <= o_watch_armed;
                        o_rd_data[ST_W_HIT] <= o_watch_hit;
                        o_rd_data[ST_L_ARMED +: LATCH_N] <= o_latch_armed;
                        o_rd_data[ST_L_HIT +: LATCH_N] <= o_latch_hit;
                    end
                    REG_FAULT: begin
                        o_rd_data[3:0] <= faults;
                    end
                    REG_HW_CAUSE: begin
                        o_rd_data[CAUSE_W-1:0] <= cause_q;
                    end
                    REG_ERR_INFO: begin
                        o_rd_data[CODE_W-1:0] <= err_code_q;
                        o_rd_data[16 +: CODE_W] <= err_id_q;
                    end
                    REG_CLASS: begin
                        o_rd_data[7:0] <= class_q;
                    end
                    REG_IRQ_STAT: begin
                        o_rd_data[EV_W-1:0] <= istat_q;
                    end
                    REG_IRQ_MASK: begin
                        o_rd_data[EV_W-1:0] <= imask_q;
                    end
                    default: begin
                        o_rd_data <= 32'h0;
                    end
                endcase
            end
        end
    end

endmodule

// ==== hw/link_miss_watchdog.sv ====
`timescale 1ns/1ps
module link_miss_watchdog
    import axis_flags_pkg::*;
#(
    parameter int LIMIT = MISS_LIMIT
) (
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic i_slot,       // One cycle per slot
    input  wire logic i_update,     // Update in this slot
    input  wire logic i_reconnect,  // Link rebuilt
    output logic      o_lost_pulse  // Pulse on limit exceeded
);

    localparam logic [3:0] LIMIT_C = 4'(LIMIT);

    link_state_e state_q;           // Up, or lost until reconnection
    logic [3:0]  miss_q;            // Consecutive misses so far

    // Count misses in a row; an update resets the run
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_q      <= LNK_UP;
            miss_q       <= 4'h0;
            o_lost_pulse <= 1'b0;
        end else begin
            o_lost_pulse <= 1'b0;
            case (state_q)
                LNK_UP: begin
                    if (i_slot && i_update) begin
                        miss_q <= 4'h0;
                    end else if (i_slot) begin
                        // LIMIT misses ride through, the next faults
                        if (miss_q == LIMIT_C) begin
                            state_q      <= LNK_LOST;  // (RL11)
                            o_lost_pulse <= 1'b1;      // (RL11)
                        end else begin
                            miss_q <= miss_q + 4'h1;   // (RL11)
                        end
                    end
                end
                LNK_LOST: begin
                    // Frozen until the link is rebuilt
                    if (i_reconnect) begin
                        state_q <= LNK_UP;
                        miss_q  <= 4'h0;
                    end
                end
                default: begin
                    state_q <= LNK_UP;
                end
            endcase
        end
    end

endmodule

// ==== verification/axis_flags_sva.sv ====
`timescale 1ns/1ps
module axis_flags_sva
    import axis_flags_pkg::*;
#(
    parameter int CAUSE_W = 8,
    parameter int CODE_W  = 8
) (
    input wire logic               i_mclk, i_sys_rst, i_wr, i_drive_en, i_shutdown_state,
    input wire logic [3:0]         i_addr,
    input wire logic [CAUSE_W-1:0] i_hw_fault_causes,
    input wire logic               i_unit_fault, i_unit_reconfig_done, i_fw_setting_update,
    input wire logic               i_update_ok, i_update_fail, i_update_slot, i_pos_update,
    input wire logic               i_link_reestablished, i_watch_event,
    input wire logic               o_drive_output_on_flag, o_axis_halted_flag, o_setting_update_pending,
    input wire logic               o_axis_hw_fault, o_unit_fatal_fault, o_setting_write_failed,
    input wire logic               o_cyclic_link_lost, o_watch_armed, o_watch_hit, o_servo_shutdown
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic [2:0] miss_q;  // Saturating
    // Own miss count
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || i_link_reestablished || (i_update_slot && i_pos_update)) begin
            miss_q <= 3'h0;
        end else if (i_update_slot && miss_q != 3'h7) begin
            miss_q <= miss_q + 3'h1;
        end
    end
    a_drive_follow: assert property (i_drive_en |=> o_drive_output_on_flag) else $error("drive flag");
    a_halt_clear: assert property (!i_shutdown_state |=> !o_axis_halted_flag) else $error("halt");
    a_pend_launch: assert property (i_fw_setting_update |=> o_setting_update_pending) else $error("pend");
    a_pend_hold: assert property (o_setting_update_pending && !i_update_ok |=> o_setting_update_pending)
        else $error("pend hold");
    a_hw_set: assert property (|i_hw_fault_causes |=> o_axis_hw_fault) else $error("hw fault");
    a_unit_hold: assert property (o_unit_fatal_fault && !i_unit_reconfig_done |=> o_unit_fatal_fault)
        else $error("unit hold");
    a_write_set: assert property (i_update_fail |=> o_setting_write_failed) else $error("write fail");
    a_link_ride: assert property (!o_cyclic_link_lost && miss_q < 3'h4 |=> !o_cyclic_link_lost)
        else $error("link early");
    a_link_trip: assert property (!o_cyclic_link_lost && i_update_slot && !i_pos_update && miss_q == 3'h4
        && !i_link_reestablished |-> ##2 o_cyclic_link_lost && o_servo_shutdown) else $error("link trip");
    a_link_clear: assert property (i_link_reestablished |=> !o_cyclic_link_lost) else $error("link clr");
    a_watch_hit: assert property (o_watch_armed && i_watch_event && !(i_wr && i_addr == REG_COMMAND)
        |=> o_watch_hit && !o_watch_armed) else $error("watch hit");
endmodule
bind axis_status_fault_flags axis_flags_sva #(.CAUSE_W(CAUSE_W), .CODE_W(CODE_W)) sva_u (.*);

// ==== verification/servo_unit_model.sv ====
`timescale 1ns/1ps
module servo_unit_model #(
    parameter logic [7:0] ERR_CODE = 8'h5A,  // Arbitrary failure code
    parameter logic [7:0] ERR_ID   = 8'hC3   // Arbitrary failure identifier
) (
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_pending,
    input  wire logic       i_fail_mode,
    input  wire logic       i_drop,
    output logic            o_update_ok,
    output logic            o_update_fail,
    output logic            o_slot,
    output logic            o_pos_update,
    output logic      [7:0] o_err_code,
    output logic      [7:0] o_err_id
);
    logic [1:0] div_q;  // Slot divider
    logic [2:0] dly_q;  // Reply delay
    logic       busy_q; // Reply in flight or given
    // Slots; a dropped link leaves them empty
    always_ff @(posedge i_mclk) begin
        div_q <= i_sys_rst ? 2'h0 : div_q + 2'h1;
    end
    assign o_slot       = (div_q == 2'h3);
    // Off-slot the update line toggles
    assign o_pos_update = o_slot ? !i_drop : div_q[0];
    // Reply a few cycles after launch
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !i_pending) begin
            busy_q <= 1'b0;
            dly_q  <= 3'h4;
        end else begin
            busy_q <= 1'b1;
            dly_q  <= (busy_q && dly_q != 3'h0) ? dly_q - 3'h1 : dly_q;
        end
        o_update_ok   <= busy_q && dly_q == 3'h1 && !i_fail_mode;
        o_update_fail <= busy_q && dly_q == 3'h1 && i_fail_mode;
        // Codes matter only beside a failed reply
        o_err_code <= (busy_q && dly_q == 3'h1) ? ERR_CODE : ~o_err_code;
        o_err_id   <= (busy_q && dly_q == 3'h1) ? ERR_ID : ~o_err_id;
    end
endmodule

// ==== verification/test_axis_status_fault_flags.sv ====
`timescale 1ns/1ps
module test_axis_status_fault_flags import axis_flags_pkg::*;;
    logic i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_drive_en = 0, i_shutdown_state = 0;
    logic i_unit_fault = 0, i_unit_reconfig_done = 0, i_fw_setting_update = 0, i_link_reestablished = 0;
    logic i_watch_event = 0, fail_mode = 0, drop = 0, i_update_ok, i_update_fail, i_update_slot, i_pos_update;
    logic o_drive_output_on_flag, o_axis_halted_flag, o_setting_update_pending, o_axis_hw_fault;
    logic o_unit_fatal_fault, o_setting_write_failed, o_cyclic_link_lost, o_watch_armed, o_watch_hit;
    logic o_major_fault, o_minor_fault, o_servo_shutdown, o_irq;
    logic [3:0]  i_addr = 0;
    logic [31:0] i_wr_data = 0, o_rd_data;
    logic [7:0]  i_hw_fault_causes = 0, i_err_code, i_err_id;
    logic [1:0]  i_latch_event = 0, o_latch_armed, o_latch_hit;
    int          err_total = 0, checked = 0;
    axis_status_fault_flags dut_u (.*);
    servo_unit_model far_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_pending(o_setting_update_pending),
        .i_fail_mode(fail_mode), .i_drop(drop), .o_update_ok(i_update_ok), .o_update_fail(i_update_fail),
        .o_slot(i_update_slot), .o_pos_update(i_pos_update), .o_err_code(i_err_code), .o_err_id(i_err_id));
    // Master clock
    initial forever #50 i_mclk = ~i_mclk;
    task automatic wrap_up();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk); i_wr <= 1'b1; i_addr <= a; i_wr_data <= d;
        @(posedge i_mclk); i_wr <= 1'b0;
    endtask
    // Read data stand one cycle; look mid-cycle
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_mclk); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_mclk); i_rd <= 1'b0;
        @(negedge i_mclk); chk("register", e, o_rd_data);
    endtask
    // Bounded wait for the reply
    task automatic wait_idle();
        for (int k = 0; k < 20 && o_setting_update_pending !== 1'b0; k++) @(posedge i_mclk);
        if (o_setting_update_pending !== 1'b0) begin
            chk("pending", 32'h0, 32'h1);
            wrap_up();
        end
    endtask
    initial begin
        #1000000;
        chk("timeout", 32'h0, 32'h1);
        wrap_up();
    end
    initial begin
        cyc(3); i_sys_rst <= 1'b0;
        rd(REG_STATUS, 32'h0); rd(REG_CLASS, {24'h0, CLASS_RST}); rd(REG_IRQ_MASK, {24'h0, MASK_RST});
        rd(4'hF, 32'h0); rd(REG_COMMAND, 32'h0);
        @(posedge i_mclk); i_drive_en <= 1'b1; i_shutdown_state <= 1'b1;
        rd(REG_STATUS, 32'h3);
        @(posedge i_mclk); i_shutdown_state <= 1'b0;
        rd(REG_STATUS, 32'h1);
        @(posedge i_mclk); i_drive_en <= 1'b0; i_fw_setting_update <= 1'b1;
        @(posedge i_mclk); i_fw_setting_update <= 1'b0;
        rd(REG_STATUS, 32'h4);
        wait_idle(); rd(REG_STATUS, 32'h0);
        wr(REG_COMMAND, 32'h40); rd(REG_STATUS, 32'h4);
        wait_idle();
        // Watch flags and interrupt
        wr(REG_IRQ_MASK, 32'h1); wr(REG_COMMAND, 32'h1); rd(REG_STATUS, 32'h8);
        @(posedge i_mclk); i_watch_event <= 1'b1;
        @(posedge i_mclk); i_watch_event <= 1'b0;
        rd(REG_STATUS, 32'h10);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(REG_IRQ_STAT, 32'h1); rd(REG_STATUS, 32'h10);
        chk("irq", 32'h0, {31'h0, o_irq});
        wr(REG_COMMAND, 32'h1); rd(REG_STATUS, 32'h8);
        wr(REG_COMMAND, 32'h2); rd(REG_STATUS, 32'h0);
        for (int i = 0; i < LATCH_N; i++) begin
            wr(REG_COMMAND, 32'h4 << i); rd(REG_STATUS, 32'h20 << i);
            @(posedge i_mclk); i_latch_event <= 2'h1 << i;
            @(posedge i_mclk); i_latch_event <= 2'h0;
            rd(REG_STATUS, 32'h80 << i);
            wr(REG_COMMAND, 32'h10 << i); rd(REG_STATUS, 32'h0);
        end
        // Unit fault survives a software clear
        @(posedge i_mclk); i_unit_fault <= 1'b1; i_hw_fault_causes <= 8'h05;
        @(posedge i_mclk); i_unit_fault <= 1'b0; i_hw_fault_causes <= 8'h00;
        rd(REG_HW_CAUSE, 32'h5); rd(REG_FAULT, 32'h3);
        chk("minor", 32'h1, {31'h0, o_minor_fault});
        wr(REG_FAULT, 32'hF); rd(REG_FAULT, 32'h2);
        @(posedge i_mclk); i_unit_reconfig_done <= 1'b1;
        @(posedge i_mclk); i_unit_reconfig_done <= 1'b0;
        rd(REG_FAULT, 32'h0);
        // Four misses ride through, six trip
        @(posedge i_mclk); drop <= 1'b1;
        cyc(16); drop <= 1'b0;
        cyc(8); chk("link", 32'h0, {31'h0, o_cyclic_link_lost});
        drop <= 1'b1;
        cyc(24); drop <= 1'b0;
        cyc(2); chk("shutdown", 32'h1, {31'h0, o_servo_shutdown});
        rd(REG_FAULT, 32'h8); chk("major", 32'h1, {31'h0, o_major_fault});
        @(posedge i_mclk); i_link_reestablished <= 1'b1;
        @(posedge i_mclk); i_link_reestablished <= 1'b0;
        rd(REG_FAULT, 32'h0);
        // Failed write, classed major
        wr(REG_CLASS, 32'h7); rd(REG_CLASS, 32'h7);
        @(posedge i_mclk); fail_mode <= 1'b1;
        wr(REG_COMMAND, 32'h40); cyc(10);
        rd(REG_FAULT, 32'h4); rd(REG_ERR_INFO, {8'h0, far_u.ERR_ID, 8'h0, far_u.ERR_CODE});
        chk("major", 32'h1, {31'h0, o_major_fault});
        wrap_up();
    end
endmodule
